// >>> design/csp_pkg.sv
// Package: constants and types for the clocked serial port
package csp_pkg;
    localparam int unsigned CSP_DATA_W    = 8;
    localparam int unsigned CSP_CNT_W     = 4;
    localparam logic [3:0]  CSP_BIT_COUNT = 4'h8;
    localparam logic [3:0]  CSP_BIT_LAST  = 4'h7;
    // Control/status register field positions
    localparam int unsigned CSP_END_FLAG_POS = 7;
    localparam int unsigned CSP_IRQ_MASK_POS = 6;
    localparam int unsigned CSP_RX_START_POS = 5;
    localparam int unsigned CSP_TX_START_POS = 4;
    localparam int unsigned CSP_SEL_LSB      = 0;
    localparam int unsigned CSP_SEL_W        = 3;
    // Reset values
    localparam logic [2:0]  CSP_SEL_RESET    = 3'h7;
    localparam logic [2:0]  CSP_SEL_EXTERNAL = 3'h7;
    localparam logic [7:0]  CSP_CTRL_RESET   = 8'h07;
    // Divider: base ratio 20, doubled per select code
    localparam int unsigned CSP_DIV_BASE   = 20;
    localparam int unsigned CSP_DIV_W      = 11;
    localparam int unsigned CSP_HALF_BASE  = CSP_DIV_BASE / 2;
    // Register addresses on the documented select port
    localparam logic [0:0]  CSP_ADDR_CTRL  = 1'h0;
    localparam logic [0:0]  CSP_ADDR_DATA  = 1'h1;
    typedef enum logic [1:0] {CSP_IDLE, CSP_TX, CSP_RX} csp_mode_t;
endpackage

// >>> design/csp_clk_div.sv
// Bit clock divider with half-period edge pulses
`timescale 1ns/1ns
module csp_clk_div
(
    clk,
    sys_rst,
    run,
    sel,
    clk_level,
    fall_pulse,
    rise_pulse
);
    import csp_pkg::*;

    input  wire logic                   clk;
    input  wire logic                   sys_rst;
    input  wire logic                   run;
    input  wire logic [CSP_SEL_W-1:0]   sel;
    output logic                        clk_level;
    output logic                        fall_pulse;
    output logic                        rise_pulse;

    logic [CSP_DIV_W-1:0] cnt_r;
    logic [CSP_DIV_W-1:0] cnt_nxt;
    logic                 lvl_r;
    logic                 lvl_nxt;
    logic [CSP_DIV_W-1:0] half_len;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        half_len   = CSP_DIV_W'(CSP_HALF_BASE) << sel;
        cnt_nxt    = cnt_r;
        lvl_nxt    = lvl_r;
        fall_pulse = 1'b0;
        rise_pulse = 1'b0;
        if (!run) begin
            // Idle high so the first edge of a transfer is a fall
            cnt_nxt = '0;
            lvl_nxt = 1'b1;
        end else if (cnt_r == half_len - CSP_DIV_W'(1)) begin
            cnt_nxt    = '0;
            lvl_nxt    = ~lvl_r;
            fall_pulse = lvl_r;
            rise_pulse = ~lvl_r;
        end else begin
            cnt_nxt = cnt_r + CSP_DIV_W'(1);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= '0;
            lvl_r <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign clk_level = lvl_r;
endmodule

// >>> design/csp_ext_edge.sv
// Edge detector for the external bit clock
`timescale 1ns/1ns
module csp_ext_edge (
    clk,
    sys_rst,
    pin_in,
    fall_pulse,
    rise_pulse
);
    input  wire logic clk;
    input  wire logic sys_rst;
    input  wire logic pin_in;
    output logic      fall_pulse;
    output logic      rise_pulse;

    logic prev_r;
    logic prev_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Pin is taken as synchronous; one flop of history is enough
    always_comb begin
        prev_nxt   = pin_in;
        fall_pulse = prev_r & ~pin_in;
        rise_pulse = ~prev_r & pin_in;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= prev_nxt;
        end
    end
endmodule

// >>> design/csp_top.sv
// Clocked serial port: control/status and shift data registers, shifter
`timescale 1ns/1ns
// Operation
// - Interrupt request is end flag gated by mask bit 6.
// - Reset clears the interrupt mask bit.
// - Writing receive start bit 5 begins receive and enables bit clock.
// - Receive shifts serial input into shift register on active bit clock.
// - After eight received bits: clear receive start, set end flag.
// - Writing transmit start bit 4 shifts register out on serial output.
// - After eight sent bits: clear transmit start, set end flag.
// - Reset and peripheral halt clear both start bits.
// - Serial input is used only while modem input select is 0.
// - Select codes 0-6 divide by 20 doubling to 1280; 7 is external.
// - Reset sets all select bits, making the clock pin an input.
// - Internal modes drive clock pin only while a transfer is enabled.
// - Clearing a start bit by software stops that operation at once.
// - Reset aborts transfers but keeps shift register contents.
// - End flag bit 7 set on completion, cleared by data access, reset, halt.
// - Shift register writes during a transfer take effect immediately.
module csp_top
(
    clk,
    sys_rst,
    reg_sel,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_rdata,
    peripheral_halt_mode,
    modem_input_select,
    serial_in_pin,
    serial_out_pin,
    serial_clock_pin_in,
    serial_clock_pin_out,
    serial_clock_pin_oe_n,
    irq
);
    import csp_pkg::*;

    input  wire logic                    clk;
    input  wire logic                    sys_rst;
    input  wire logic [0:0]              reg_sel;
    input  wire logic                    reg_wr;
    input  wire logic                    reg_rd;
    input  wire logic [CSP_DATA_W-1:0]   reg_wdata;
    output logic [CSP_DATA_W-1:0]        reg_rdata;
    input  wire logic                    peripheral_halt_mode;
    input  wire logic                    modem_input_select;
    input  wire logic                    serial_in_pin;
    output logic                         serial_out_pin;
    input  wire logic                    serial_clock_pin_in;
    output logic                         serial_clock_pin_out;
    output logic                         serial_clock_pin_oe_n;
    output logic                         irq;

    logic                    end_flag_r;
    logic                    end_flag_nxt;
    logic                    done_irq_mask_r;
    logic                    done_irq_mask_nxt;
    logic                    rx_start_bit_r;
    logic                    rx_start_bit_nxt;
    logic                    tx_start_bit_r;
    logic                    tx_start_bit_nxt;
    logic [CSP_SEL_W-1:0]    clock_divider_select_r;
    logic [CSP_SEL_W-1:0]    clock_divider_select_nxt;
    logic [CSP_DATA_W-1:0]   shift_data_register_r;
    logic [CSP_DATA_W-1:0]   shift_data_register_nxt;
    logic [CSP_CNT_W-1:0]    bit_cnt_r;
    logic [CSP_CNT_W-1:0]    bit_cnt_nxt;
    logic                    tx_out_r;
    logic                    tx_out_nxt;
    logic [CSP_DATA_W-1:0]   rdata_r;
    logic [CSP_DATA_W-1:0]   rdata_nxt;

    logic                    ext_mode;
    logic                    active;
    logic                    int_level;
    logic                    int_fall;
    logic                    int_rise;
    logic                    ext_fall;
    logic                    ext_rise;
    logic                    bit_fall;
    logic                    bit_rise;
    logic                    rx_data;
    logic                    ctrl_wr;
    logic                    data_acc;
    logic                    done;
    logic [CSP_DATA_W-1:0]   ctrl_view;

    csp_mode_t               mode_r;
    csp_mode_t               mode_nxt;
    logic                    tx_run;
    logic                    rx_run;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks on the package constants the logic leans on
    if ((CSP_HALF_BASE << CSP_SEL_EXTERNAL) >= (1 << CSP_DIV_W)) begin : g_div_too_narrow
        $error("divider counter too narrow for the slowest rate");
    end
    if ((CSP_HALF_BASE * 2) != CSP_DIV_BASE) begin : g_div_base_odd
        $error("divider base ratio must be even");
    end
    if (CSP_BIT_COUNT != CSP_CNT_W'(CSP_DATA_W)) begin : g_bit_count
        $error("bit count must match the data width");
    end
    if (CSP_BIT_LAST != CSP_BIT_COUNT - 4'h1) begin : g_bit_last
        $error("last bit index must be one below the bit count");
    end
    if ((CSP_SEL_LSB + CSP_SEL_W) > CSP_TX_START_POS) begin : g_sel_field
        $error("select field overlaps the start bits");
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit clock sources
    assign ext_mode = (clock_divider_select_r == CSP_SEL_EXTERNAL);
    assign active   = rx_start_bit_r | tx_start_bit_r;

    csp_clk_div u_div (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .run        (active & ~ext_mode),
        .sel        (clock_divider_select_r),
        .clk_level  (int_level),
        .fall_pulse (int_fall),
        .rise_pulse (int_rise)
    );

    csp_ext_edge u_ext (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .pin_in     (serial_clock_pin_in),
        .fall_pulse (ext_fall),
        .rise_pulse (ext_rise)
    );

    assign bit_fall = active & (ext_mode ? ext_fall : int_fall);
    assign bit_rise = active & (ext_mode ? ext_rise : int_rise);

    // Shared pin: a high select hands it to the other channel's modem input
    assign rx_data = modem_input_select ? 1'b1 : serial_in_pin;

    ////////////////////////////////////////////////////////////////////////
    // Transfer mode decode
    always_comb begin
        tx_run = 1'b0;
        rx_run = 1'b0;
        case (mode_r)
            CSP_TX: begin
                tx_run = 1'b1;
            end
            CSP_RX: begin
                rx_run = 1'b1;
            end
            CSP_IDLE: begin
                tx_run = 1'b0;
                rx_run = 1'b0;
            end
            default: begin
                tx_run = 1'b0;
                rx_run = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register access and transfer sequencing
    assign ctrl_wr  = reg_wr & (reg_sel == CSP_ADDR_CTRL);
    assign data_acc = (reg_wr | reg_rd) & (reg_sel == CSP_ADDR_DATA);

    always_comb begin
        end_flag_nxt             = end_flag_r;
        done_irq_mask_nxt        = done_irq_mask_r;
        rx_start_bit_nxt         = rx_start_bit_r;
        tx_start_bit_nxt         = tx_start_bit_r;
        clock_divider_select_nxt = clock_divider_select_r;
        shift_data_register_nxt  = shift_data_register_r;
        bit_cnt_nxt              = bit_cnt_r;
        tx_out_nxt               = tx_out_r;
        done                     = 1'b0;

        // Transmit: present next bit on falling edge, LSB first
        if (tx_run && bit_fall) begin
            tx_out_nxt              = shift_data_register_r[0];
            shift_data_register_nxt = {1'b1, shift_data_register_r[CSP_DATA_W-1:1]};
            bit_cnt_nxt             = bit_cnt_r + CSP_CNT_W'(1);
        end
        // Receive: sample on rising edge into the MSB, shifting right
        if (rx_run && bit_rise) begin
            shift_data_register_nxt = {rx_data, shift_data_register_r[CSP_DATA_W-1:1]};
            bit_cnt_nxt             = bit_cnt_r + CSP_CNT_W'(1);
            if (bit_cnt_r == CSP_BIT_LAST) begin
                rx_start_bit_nxt = 1'b0;
                done             = 1'b1;
            end
        end
        // Transmit ends after the last bit's rising edge
        if (tx_run && bit_rise && bit_cnt_r == CSP_BIT_COUNT) begin
            tx_start_bit_nxt = 1'b0;
            done             = 1'b1;
        end

        // Unbuffered data register: write lands in the live shifter
        if (reg_wr && reg_sel == CSP_ADDR_DATA) begin
            shift_data_register_nxt = reg_wdata;
        end
        if (data_acc) begin
            end_flag_nxt = 1'b0;
        end

        if (ctrl_wr) begin
            done_irq_mask_nxt        = reg_wdata[CSP_IRQ_MASK_POS];
            clock_divider_select_nxt = reg_wdata[CSP_SEL_LSB +: CSP_SEL_W];
            // Clearing a start bit stops at once; setting one restarts the count
            rx_start_bit_nxt = reg_wdata[CSP_RX_START_POS];
            tx_start_bit_nxt = reg_wdata[CSP_TX_START_POS];
            if ((reg_wdata[CSP_RX_START_POS] && !rx_start_bit_r) ||
                (reg_wdata[CSP_TX_START_POS] && !tx_start_bit_r)) begin
                bit_cnt_nxt = '0;
            end
        end

        // Completion set wins over a same-cycle data access clear
        if (done) begin
            end_flag_nxt = 1'b1;
        end

        if (peripheral_halt_mode) begin
            rx_start_bit_nxt = 1'b0;
            tx_start_bit_nxt = 1'b0;
            end_flag_nxt     = 1'b0;
        end
        if (!rx_start_bit_nxt && !tx_start_bit_nxt) begin
            bit_cnt_nxt = '0;
        end

        // One direction at a time; receive wins if both start bits are set
        if (rx_start_bit_nxt) begin
            mode_nxt = CSP_RX;
        end else if (tx_start_bit_nxt) begin
            mode_nxt = CSP_TX;
        end else begin
            mode_nxt = CSP_IDLE;
        end
    end

    // Shift register keeps its contents through reset
    always_ff @(posedge clk) begin
        shift_data_register_r <= shift_data_register_nxt;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            end_flag_r             <= 1'b0;
            done_irq_mask_r        <= 1'b0;
            rx_start_bit_r         <= 1'b0;
            tx_start_bit_r         <= 1'b0;
            clock_divider_select_r <= CSP_SEL_RESET;
            bit_cnt_r              <= '0;
            tx_out_r               <= 1'b1;
            mode_r                 <= CSP_IDLE;
        end else begin
            end_flag_r             <= end_flag_nxt;
            done_irq_mask_r        <= done_irq_mask_nxt;
            rx_start_bit_r         <= rx_start_bit_nxt;
            tx_start_bit_r         <= tx_start_bit_nxt;
            clock_divider_select_r <= clock_divider_select_nxt;
            bit_cnt_r              <= bit_cnt_nxt;
            tx_out_r               <= tx_out_nxt;
            mode_r                 <= mode_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and pins
    always_comb begin
        ctrl_view                             = '0;
        ctrl_view[CSP_END_FLAG_POS]           = end_flag_r;
        ctrl_view[CSP_IRQ_MASK_POS]           = done_irq_mask_r;
        ctrl_view[CSP_RX_START_POS]           = rx_start_bit_r;
        ctrl_view[CSP_TX_START_POS]           = tx_start_bit_r;
        ctrl_view[CSP_SEL_LSB +: CSP_SEL_W]   = clock_divider_select_r;
        rdata_nxt = (reg_sel == CSP_ADDR_DATA) ? shift_data_register_r : ctrl_view;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata             = rdata_r;
    assign serial_out_pin        = tx_out_r;
    assign serial_clock_pin_out  = int_level;
    assign serial_clock_pin_oe_n = ~(active & ~ext_mode);
    assign irq                   = end_flag_r & done_irq_mask_r;
endmodule

// >>> testbench/csp_top_checker.sv
// Port-level properties of the clocked serial port
`timescale 1ns/1ns
module csp_top_checker (
    input wire logic                              clk,
    input wire logic                              sys_rst,
    input wire logic [0:0]                        reg_sel,
    input wire logic                              reg_wr,
    input wire logic [csp_pkg::CSP_DATA_W-1:0]    reg_wdata,
    input wire logic                              peripheral_halt_mode,
    input wire logic                              serial_out_pin,
    input wire logic                              serial_clock_pin_out,
    input wire logic                              serial_clock_pin_oe_n,
    input wire logic                              irq
);
    import csp_pkg::*;
    logic [2:0] sel_r;
    logic       mask_r;
    // Shadow of select and mask, so the pins can be judged
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_r  <= CSP_SEL_RESET;
            mask_r <= 1'b0;
        end else if (reg_wr && reg_sel == CSP_ADDR_CTRL) begin
            sel_r  <= reg_wdata[2:0];
            mask_r <= reg_wdata[CSP_IRQ_MASK_POS];
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_irq_mask: assert property (irq |-> mask_r)
        else $error("irq raised with mask clear");
    a_reset_vals: assert property ($fell(sys_rst) |-> serial_clock_pin_oe_n && !irq && serial_out_pin)
        else $error("pins wrong after reset");
    a_ext_input: assert property (sel_r == CSP_SEL_EXTERNAL |-> serial_clock_pin_oe_n)
        else $error("clock pin driven in external mode");
    a_first_half: assert property ($fell(serial_clock_pin_oe_n) && sel_r == 3'h0
        |-> serial_clock_pin_out [*8] ##[1:5] !serial_clock_pin_out)
        else $error("bit clock start wrong");
    a_done_bound: assert property ($fell(serial_clock_pin_oe_n) && sel_r == 3'h0
        |-> ##[150:170] $rose(serial_clock_pin_oe_n))
        else $error("transfer length wrong");
    a_halt_idle: assert property (peripheral_halt_mode |=> serial_clock_pin_oe_n)
        else $error("halt left clock pin driven");
    a_halt_flag: assert property (peripheral_halt_mode |=> !irq)
        else $error("halt left end flag set");
    a_out_on_fall: assert property ($changed(serial_out_pin) && sel_r != CSP_SEL_EXTERNAL
        |-> $fell(serial_clock_pin_out))
        else $error("data changed off the falling edge");
    c_tx_done: cover property ($rose(serial_clock_pin_oe_n) && sel_r == 3'h0);
    c_irq: cover property ($rose(irq));
    c_halt: cover property (peripheral_halt_mode && !serial_clock_pin_oe_n);
endmodule
bind csp_top csp_top_checker i_chk (
    .clk(clk), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .peripheral_halt_mode(peripheral_halt_mode), .serial_out_pin(serial_out_pin),
    .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe_n(serial_clock_pin_oe_n), .irq(irq));

// >>> testbench/csp_link_peer.sv
// Far-side serial peer: byte sender, byte catcher, external clock
`timescale 1ns/1ns
module csp_link_peer (
    input wire logic sck,
    input wire logic sdo,
    output logic     sdi,
    output logic     sck_drv
);
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] rx_byte = 8'h00;
    int         idx = 8;
    initial sdi = 1'b0;
    initial sck_drv = 1'b1;
    task automatic arm(input logic [7:0] b);
        tx_byte = b;
        idx = 0;
    endtask
    // Clock idles high, stands still between frames
    task automatic ext_frame(input int half);
        repeat (8) begin
            #half sck_drv = 1'b0;
            #half sck_drv = 1'b1;
        end
    endtask
    always @(negedge sck) begin
        if (idx < 8) begin
            sdi = tx_byte[idx];
            idx++;
        end
    end
    // Hold runs out after the last bit, so the line flips
    always @(posedge sck) begin
        rx_byte = {sdo, rx_byte[7:1]};
        #100 if (idx == 8) sdi = ~sdi;
    end
endmodule

// >>> testbench/csp_top_bench.sv
// Self-checking bench for the clocked serial port
`timescale 1ns/1ns
module csp_top_bench;
    import csp_pkg::*;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [0:0] reg_sel = 1'b0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic       halt = 1'b0;
    logic       modem_sel = 1'b0;
    logic [7:0] reg_rdata;
    logic       sdo, sck_out, sck_oe_n, irq, sdi, peer_sck;
    wire        sck = sck_oe_n ? peer_sck : sck_out;
    int         num_errors = 0;
    int         num_checks = 0;
    int         cycles = 0;
    always #5 clk = ~clk;
    csp_top i_dut (.clk(clk), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .peripheral_halt_mode(halt),
        .modem_input_select(modem_sel), .serial_in_pin(sdi), .serial_out_pin(sdo),
        .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_out), .serial_clock_pin_oe_n(sck_oe_n), .irq(irq));
    csp_link_peer i_peer (.sck(sck), .sdo(sdo), .sdi(sdi), .sck_drv(peer_sck));
    ////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [0:0] s, input logic [7:0] d);
        @(posedge clk);
        reg_sel <= s;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [0:0] s, output logic [7:0] d);
        @(posedge clk);
        reg_sel <= s;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    task automatic rdchk(input logic [0:0] s, input logic [7:0] e);
        logic [7:0] v;
        rd(s, v);
        check(v, e);
    endtask
    // Polled wait, bounded so a stuck start bit cannot hang the run
    task automatic wait_idle(input int pos);
        logic [7:0] v = 8'hff;
        for (int i = 0; i < 400 && v[pos]; i++) rd(1'b0, v);
        check({7'h0, v[pos]}, 8'h00);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk(1'b0, CSP_CTRL_RESET);
        check({7'h0, irq}, 8'h00);
        wr(1'b0, 8'h40);
        wr(1'b1, 8'ha5);
        wr(1'b0, 8'h50);
        wait_idle(4);
        check(i_peer.rx_byte, 8'ha5);
        rdchk(1'b0, 8'hc0);
        check({7'h0, irq}, 8'h01);
        wr(1'b1, 8'h00);
        rdchk(1'b0, 8'h40);
        repeat (50) @(posedge clk);
        i_peer.arm(8'h3c);
        wr(1'b0, 8'h01);
        wr(1'b0, 8'h21);
        wait_idle(5);
        rdchk(1'b0, 8'h81);
        check({7'h0, irq}, 8'h00);
        rdchk(1'b1, 8'h3c);
        @(posedge clk);
        modem_sel <= 1'b1;
        i_peer.arm(8'h00);
        wr(1'b0, 8'h21);
        wait_idle(5);
        rdchk(1'b1, 8'hff);
        modem_sel <= 1'b0;
        repeat (50) @(posedge clk);
        wr(1'b0, 8'h07);
        wr(1'b1, 8'h96);
        wr(1'b0, 8'h17);
        i_peer.ext_frame(153);
        wait_idle(4);
        check(i_peer.rx_byte, 8'h96);
        wr(1'b1, 8'h00);
        wr(1'b0, 8'h01);
        wr(1'b0, 8'h11);
        repeat (50) @(posedge clk);
        wr(1'b0, 8'h01);
        @(negedge clk);
        check({7'h0, sck_oe_n}, 8'h01);
        rdchk(1'b0, 8'h01);
        wr(1'b0, 8'h11);
        @(posedge clk);
        halt <= 1'b1;
        rdchk(1'b0, 8'h01);
        halt <= 1'b0;
        wr(1'b1, 8'hc3);
        wr(1'b0, 8'h11);
        repeat (5) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk(1'b0, 8'h07);
        rdchk(1'b1, 8'hc3);
        report_and_stop();
    end
endmodule
